// file: hdl/cdr_diag_error_regs.sv
`timescale 1ns/100ps
// Overview of operation
// - Index-load-tag on data cache loads data-cache low register.
// - Way-select test set: index-store-data writes data-cache low to cache.
// - Scratchpad test set: index-store-data writes register to scratchpad.
// - Build option makes icache/dcache data registers read-only zero to moves; index-store-data still sends their unreset contents.
// - L2/L3 low loaded by load-tag, stored to cache or scratchpad.
// - Without L2/L3 support both L2/L3 data registers read zero.
// - Icache path moves instruction pairs; higher address to high register if little-endian.
// - Pair follows memory order: first to high if big-endian, else low.
// - L2/L3 high loaded by load-tag, stored to cache under way-select.
// - Error return address captures PC on error, reset, soft reset, NMI.
// - Captured address is faulting instruction, or branch if in delay slot.
// - No branch-delay-slot indicator exists for error return address.
// - Without compressed ISA all 32 error return address bits are software writable; with it, written bit 0 goes to the mode.
// - On reset, holds address where first thread context would resume.
// - Compressed ISA: read gives PC upper 31 bits with mode bit 0.
// - Compressed ISA: write clears PC bit 0, mode gets 0 and GPR bit 0.
// - Debug scratch is plain 32-bit storage without side effects.
// - One reset input serves power-up and soft reset alike.
// - Reset leaves these data registers uninitialised by software view.
module cdr_diag_error_regs
  import cdr_pkg::*;
#(
  parameter bit HAS_L1_DIAG = 1'b1,
  parameter bit HAS_L2L3 = 1'b1,
  parameter bit HAS_COMPRESSED = 1'b1
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Configuration and error-control test bits
  input wire logic big_endian,
  input wire logic way_select_test_enable,
  input wire logic scratchpad_test_enable,
  // Coprocessor moves
  input wire cdr_move_type move_req,
  output logic [31:0] move_rdata,
  // Cache-maintenance operations
  input wire cdr_cacheop_type cache_op,
  output cdr_target_type store_target,
  output logic store_valid,
  output logic [31:0] store_word_lo,
  output logic [31:0] store_word_hi,
  // Error exception entry
  input wire cdr_errexc_type err_exc,
  output logic [1:0] instruction_set_mode
);

  logic [31:0] icache_diag_data_low_q, icache_diag_data_low_d;
  logic [31:0] icache_diag_data_high_q, icache_diag_data_high_d;
  logic [31:0] dcache_diag_data_low_q, dcache_diag_data_low_d;
  logic [31:0] l2l3_diag_data_low_q, l2l3_diag_data_low_d;
  logic [31:0] l2l3_diag_data_high_q, l2l3_diag_data_high_d;
  logic [31:0] error_return_address_q, error_return_address_d;
  logic [31:0] debug_scratch_save_q, debug_scratch_save_d;
  logic [1:0] isa_mode_q, isa_mode_d;
  logic [31:0] rdata_q, rdata_d;
  cdr_target_type target_q, target_d;
  logic [31:0] st_lo_q, st_lo_d, st_hi_q, st_hi_d;
  logic wr_icl, wr_ich, wr_dcl, wr_l2l, wr_l2h;

  function automatic logic hit(input cdr_move_type m, input logic [7:0] a);
    return m.wr && (m.addr == a);
  endfunction

  // Writes to absent registers fall away
  assign wr_icl = HAS_L1_DIAG && hit(move_req, ADDR_ICACHE_LOW);
  assign wr_ich = HAS_L1_DIAG && hit(move_req, ADDR_ICACHE_HIGH);
  assign wr_dcl = HAS_L1_DIAG && hit(move_req, ADDR_DCACHE_LOW);
  assign wr_l2l = HAS_L2L3 && hit(move_req, ADDR_L2L3_LOW);
  assign wr_l2h = HAS_L2L3 && hit(move_req, ADDR_L2L3_HIGH);

  always_comb begin
    icache_diag_data_low_d = icache_diag_data_low_q;
    icache_diag_data_high_d = icache_diag_data_high_q;
    dcache_diag_data_low_d = dcache_diag_data_low_q;
    l2l3_diag_data_low_d = l2l3_diag_data_low_q;
    l2l3_diag_data_high_d = l2l3_diag_data_high_q;
    // Cache loads take priority over a move in the same cycle
    if (wr_icl) icache_diag_data_low_d = move_req.wdata;
    if (wr_ich) icache_diag_data_high_d = move_req.wdata;
    if (wr_dcl) dcache_diag_data_low_d = move_req.wdata;
    if (wr_l2l) l2l3_diag_data_low_d = move_req.wdata;
    if (wr_l2h) l2l3_diag_data_high_d = move_req.wdata;
    if (cache_op.load_tag) begin
      unique case (cache_op.array_sel)
        ARR_ICACHE: begin
          // Pair split; memory order by endianness
          if (HAS_L1_DIAG) begin
            icache_diag_data_high_d =
              big_endian ? cache_op.word_lo : cache_op.word_hi;
            icache_diag_data_low_d =
              big_endian ? cache_op.word_hi : cache_op.word_lo;
          end
        end
        ARR_DCACHE: begin
          if (HAS_L1_DIAG) dcache_diag_data_low_d = cache_op.word_lo;
        end
        ARR_L2L3: begin
          if (HAS_L2L3) begin
            l2l3_diag_data_low_d = cache_op.word_lo;
            l2l3_diag_data_high_d = cache_op.word_hi;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Single reset; data registers hold no reset value
  always_ff @(posedge ref_clk) begin
    icache_diag_data_low_q <= icache_diag_data_low_d;
    icache_diag_data_high_q <= icache_diag_data_high_d;
    dcache_diag_data_low_q <= dcache_diag_data_low_d;
    l2l3_diag_data_low_q <= l2l3_diag_data_low_d;
    l2l3_diag_data_high_q <= l2l3_diag_data_high_d;
    debug_scratch_save_q <= debug_scratch_save_d;
  end

  always_comb begin
    debug_scratch_save_d = debug_scratch_save_q;
    if (hit(move_req, ADDR_DBG_SAVE)) debug_scratch_save_d = move_req.wdata;
  end

  // Error return address and mode; exception entry beats a software write
  always_comb begin
    error_return_address_d = error_return_address_q;
    isa_mode_d = isa_mode_q;
    if (hit(move_req, ADDR_ERR_RET)) begin
      if (HAS_COMPRESSED) begin
        // Split write between PC and mode
        error_return_address_d = {move_req.wdata[31:1], 1'b0};
        isa_mode_d = {1'b0, move_req.wdata[PC_LSB_POS]};
      end else begin
        error_return_address_d = move_req.wdata;
      end
    end
    // Capture on error, reset, soft reset or NMI entry
    if (err_exc.take) begin
      // Mode of the interrupted code rides along with the captured PC
      if (HAS_COMPRESSED) isa_mode_d = err_exc.isa_mode;
      if (err_exc.is_reset)
        // Resume point of first thread context
        error_return_address_d = err_exc.tc0_resume_pc;
      else
        // Branch address when in delay slot; no slot flag kept
        error_return_address_d =
          err_exc.in_delay_slot ? err_exc.branch_pc : err_exc.pc;
    end
  end

  always_ff @(posedge ref_clk) begin
    error_return_address_q <= error_return_address_d;
    if (rst) isa_mode_q <= ISA_MODE_RESET;
    else isa_mode_q <= isa_mode_d;
  end

  // Read mux, registered so data leaves from flip-flops
  always_comb begin
    rdata_d = ZERO_WORD;
    if (move_req.rd) begin
      unique case (move_req.addr)
        ADDR_ICACHE_LOW:
          rdata_d = HAS_L1_DIAG ? icache_diag_data_low_q : ZERO_WORD;
        ADDR_ICACHE_HIGH:
          rdata_d = HAS_L1_DIAG ? icache_diag_data_high_q : ZERO_WORD;
        ADDR_DCACHE_LOW:
          rdata_d = HAS_L1_DIAG ? dcache_diag_data_low_q : ZERO_WORD;
        ADDR_L2L3_LOW:
          rdata_d = HAS_L2L3 ? l2l3_diag_data_low_q : ZERO_WORD;
        ADDR_L2L3_HIGH:
          rdata_d = HAS_L2L3 ? l2l3_diag_data_high_q : ZERO_WORD;
        // Mode bit replaces PC bit 0
        ADDR_ERR_RET:
          rdata_d = HAS_COMPRESSED ?
            {error_return_address_q[31:1], isa_mode_q[0]} :
            error_return_address_q;
        ADDR_DBG_SAVE: rdata_d = debug_scratch_save_q;
        default: rdata_d = ZERO_WORD;
      endcase
    end
  end

  // Store-data routing; scratchpad test wins if both bits are set
  always_comb begin
    target_d = CDR_TGT_NONE;
    st_lo_d = ZERO_WORD;
    st_hi_d = ZERO_WORD;
    if (cache_op.store_data) begin
      unique case (cache_op.array_sel)
        ARR_ICACHE: begin
          st_lo_d = icache_diag_data_low_q;
          st_hi_d = icache_diag_data_high_q;
        end
        ARR_DCACHE: st_lo_d = dcache_diag_data_low_q;
        ARR_L2L3: begin
          st_lo_d = l2l3_diag_data_low_q;
          st_hi_d = l2l3_diag_data_high_q;
        end
        default: begin
        end
      endcase
      if (scratchpad_test_enable) begin
        target_d = CDR_TGT_SPAD;
        // High L2/L3 register has no scratchpad path
        if (cache_op.array_sel == ARR_L2L3) st_hi_d = ZERO_WORD;
      end
      // Cache array path; also covers L2/L3 high
      else if (way_select_test_enable) target_d = CDR_TGT_CACHE;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdata_q <= ZERO_WORD;
      target_q <= CDR_TGT_NONE;
      st_lo_q <= ZERO_WORD;
      st_hi_q <= ZERO_WORD;
    end else begin
      rdata_q <= rdata_d;
      target_q <= target_d;
      st_lo_q <= st_lo_d;
      st_hi_q <= st_hi_d;
    end
  end

  assign move_rdata = rdata_q;
  assign store_target = target_q;
  assign store_valid = (target_q != CDR_TGT_NONE);
  assign store_word_lo = st_lo_q;
  assign store_word_hi = st_hi_q;
  assign instruction_set_mode = isa_mode_q;

  // Way-select store reaches the cache next cycle
  chk_store_to_cache: assert property (@(posedge ref_clk) disable iff (rst)
    cache_op.store_data && way_select_test_enable && !scratchpad_test_enable
    |=> store_target == CDR_TGT_CACHE)
    else $error("store did not target cache");

  chk_store_to_spad: assert property (@(posedge ref_clk) disable iff (rst)
    cache_op.store_data && scratchpad_test_enable
    |=> store_target == CDR_TGT_SPAD)
    else $error("store did not target scratchpad");

  chk_dcache_load: assert property (@(posedge ref_clk) disable iff (rst)
    HAS_L1_DIAG && cache_op.load_tag && cache_op.array_sel == ARR_DCACHE
    && !move_req.wr ##1 move_req.rd && move_req.addr == ADDR_DCACHE_LOW
    && !cache_op.load_tag |=> move_rdata == $past(cache_op.word_lo, 2))
    else $error("dcache low not loaded");

  chk_l2l3_zero: assert property (@(posedge ref_clk) disable iff (rst)
    !HAS_L2L3 && move_req.rd && (move_req.addr == ADDR_L2L3_LOW ||
    move_req.addr == ADDR_L2L3_HIGH) |=> move_rdata == ZERO_WORD)
    else $error("absent L2/L3 read nonzero");

  chk_pair_order: assert property (@(posedge ref_clk) disable iff (rst)
    HAS_L1_DIAG && cache_op.load_tag && cache_op.array_sel == ARR_ICACHE
    && !move_req.wr |=> icache_diag_data_high_q ==
    ($past(big_endian) ? $past(cache_op.word_lo) : $past(cache_op.word_hi)))
    else $error("instruction pair misordered");

  chk_delay_slot: assert property (@(posedge ref_clk) disable iff (rst)
    err_exc.take && !err_exc.is_reset && err_exc.in_delay_slot
    |=> error_return_address_q == $past(err_exc.branch_pc))
    else $error("delay slot capture wrong");

  chk_reset_resume: assert property (@(posedge ref_clk) disable iff (rst)
    err_exc.take && err_exc.is_reset
    |=> error_return_address_q == $past(err_exc.tc0_resume_pc))
    else $error("reset resume address wrong");

  // Compressed write clears PC bit 0 and mode upper bit
  chk_split_write: assert property (@(posedge ref_clk) disable iff (rst)
    HAS_COMPRESSED && hit(move_req, ADDR_ERR_RET) && !err_exc.take
    |=> !error_return_address_q[0] && !instruction_set_mode[1] &&
    instruction_set_mode[0] == $past(move_req.wdata[0]))
    else $error("split write wrong");

  // Scratch write then read returns data
  chk_scratch_rw: assert property (@(posedge ref_clk) disable iff (rst)
    hit(move_req, ADDR_DBG_SAVE) ##1 move_req.rd &&
    move_req.addr == ADDR_DBG_SAVE && !move_req.wr
    |=> move_rdata == $past(move_req.wdata, 2))
    else $error("scratch readback wrong");

  cov_icache_load: cover property (@(posedge ref_clk)
    cache_op.load_tag && cache_op.array_sel == ARR_ICACHE);
  cov_spad_store: cover property (@(posedge ref_clk)
    store_target == CDR_TGT_SPAD);
  cov_err_capture: cover property (@(posedge ref_clk)
    err_exc.take && err_exc.in_delay_slot);

endmodule

// file: hdl/cdr_pkg.sv
package cdr_pkg;

  // Coprocessor register number and select, packed as {num[4:0], sel[2:0]}
  localparam logic [7:0] ADDR_ICACHE_LOW = 8'hE1;
  localparam logic [7:0] ADDR_DCACHE_LOW = 8'hE3;
  localparam logic [7:0] ADDR_L2L3_LOW = 8'hE5;
  localparam logic [7:0] ADDR_ICACHE_HIGH = 8'hE9;
  localparam logic [7:0] ADDR_L2L3_HIGH = 8'hED;
  localparam logic [7:0] ADDR_ERR_RET = 8'hF0;
  localparam logic [7:0] ADDR_DBG_SAVE = 8'hF8;

  localparam int PC_LSB_POS = 0;
  localparam logic [1:0] ISA_MODE_RESET = 2'h0;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

  typedef enum logic [1:0] {
    CDR_TGT_NONE = 2'h0,
    CDR_TGT_CACHE = 2'h1,
    CDR_TGT_SPAD = 2'h2
  } cdr_target_type;

  // Coprocessor move request from the pipeline
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } cdr_move_type;

  // Cache-maintenance operation from the cache controller
  typedef struct packed {
    logic load_tag;
    logic store_data;
    logic [1:0] array_sel;
    logic [31:0] word_lo;
    logic [31:0] word_hi;
  } cdr_cacheop_type;

  typedef struct packed {
    logic take;
    logic in_delay_slot;
    logic [31:0] pc;
    logic [31:0] branch_pc;
    logic [31:0] tc0_resume_pc;
    logic is_reset;
    logic [1:0] isa_mode;
  } cdr_errexc_type;

  localparam logic [1:0] ARR_ICACHE = 2'h0;
  localparam logic [1:0] ARR_DCACHE = 2'h1;
  localparam logic [1:0] ARR_L2L3 = 2'h2;

endpackage

// file: tb/tb.sv
`timescale 1ns/100ps
`define CHK(what, exp, got) begin checks++; if ((got) !== (exp)) begin \
  num_errors++; $display("CHECK FAILED %s expected %h seen %h", what, exp, \
  got); end end
module tb
  import cdr_pkg::*;
;
  logic ref_clk, rst, big_endian, way_select_test_enable;
  logic scratchpad_test_enable, valid_u;
  cdr_move_type move_req;
  cdr_cacheop_type cache_op;
  cdr_errexc_type err_exc;
  cdr_target_type tgt_u, exp_tgt;
  logic [31:0] rdata_u, rdata_z, lo_u, hi_u, v;
  logic [31:0] exp_lo [3];
  logic [31:0] exp_hi [3];
  logic [31:0] vals [3];
  logic [1:0] mode_u, mode_z;
  int num_errors, checks;

  cdr_diag_error_regs dut_u (.ref_clk(ref_clk), .rst(rst),
    .big_endian(big_endian), .way_select_test_enable(way_select_test_enable),
    .scratchpad_test_enable(scratchpad_test_enable), .move_req(move_req),
    .move_rdata(rdata_u), .cache_op(cache_op), .store_target(tgt_u),
    .store_valid(valid_u), .store_word_lo(lo_u), .store_word_hi(hi_u),
    .err_exc(err_exc), .instruction_set_mode(mode_u));

  // Reduced build shares all stimulus so absent registers read zero
  cdr_diag_error_regs #(.HAS_L1_DIAG(1'b0), .HAS_L2L3(1'b0),
    .HAS_COMPRESSED(1'b0)) dut_z (.ref_clk(ref_clk), .rst(rst),
    .big_endian(big_endian), .way_select_test_enable(way_select_test_enable),
    .scratchpad_test_enable(scratchpad_test_enable), .move_req(move_req),
    .move_rdata(rdata_z), .cache_op(cache_op), .store_target(),
    .store_valid(), .store_word_lo(), .store_word_hi(), .err_exc(err_exc),
    .instruction_set_mode(mode_z));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic finish_test;
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Requests last one cycle; outputs are sampled at the releasing edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge ref_clk);
    move_req = '{1'b1, 1'b0, a, d};
    @(negedge ref_clk);
    move_req = '0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(negedge ref_clk);
    move_req = '{1'b0, 1'b1, a, 32'h0000_0000};
    @(negedge ref_clk);
    move_req = '0;
  endtask

  // Back-to-back write then read of one register, no idle cycle between
  task automatic wr_rd(input logic [7:0] a, input logic [31:0] d);
    @(negedge ref_clk);
    move_req = '{1'b1, 1'b0, a, d};
    @(negedge ref_clk);
    move_req = '{1'b0, 1'b1, a, 32'h0000_0000};
    @(negedge ref_clk);
    move_req = '0;
  endtask

  // Load-tag followed directly by a read in the next cycle
  task automatic load_rd(input logic [1:0] sel, input logic [31:0] wl,
                         input logic [31:0] wh, input logic [7:0] a);
    @(negedge ref_clk);
    cache_op = '{1'b1, 1'b0, sel, wl, wh};
    @(negedge ref_clk);
    cache_op = '0;
    move_req = '{1'b0, 1'b1, a, 32'h0000_0000};
    @(negedge ref_clk);
    move_req = '0;
  endtask

  task automatic cop(input logic lt, input logic st, input logic [1:0] sel,
                     input logic [31:0] wl, input logic [31:0] wh);
    @(negedge ref_clk);
    cache_op = '{lt, st, sel, wl, wh};
    @(negedge ref_clk);
    cache_op = '0;
  endtask

  task automatic exc(input logic ds, input logic rs, input logic [31:0] pc,
                     input logic [31:0] bpc, input logic [31:0] tpc);
    @(negedge ref_clk);
    err_exc = '{1'b1, ds, pc, bpc, tpc, rs, 2'h0};
    @(negedge ref_clk);
    err_exc = '0;
  endtask

  // A hang is cut short here rather than left to the simulator
  initial begin
    repeat (20000) @(posedge ref_clk);
    num_errors++;
    finish_test;
  end

  initial begin
    num_errors = 0;
    checks = 0;
    rst = 1'b1;
    big_endian = 1'b0;
    way_select_test_enable = 1'b0;
    scratchpad_test_enable = 1'b0;
    move_req = '0;
    cache_op = '0;
    err_exc = '0;
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
    rst = 1'b0;
    `CHK("rdata_rst", 32'h0000_0000, rdata_u)
    `CHK("valid_rst", 1'b0, valid_u)
    `CHK("mode_rst", 2'h0, mode_u)
    wr(ADDR_DBG_SAVE, 32'hA5A5_5A5A);
    wr_rd(ADDR_DBG_SAVE, 32'h0123_4567);
    `CHK("dbg_save", 32'h0123_4567, rdata_u)
    `CHK("dbg_save_z", 32'h0123_4567, rdata_z)
    @(negedge ref_clk);
    `CHK("rdata_idle", 32'h0000_0000, rdata_u)
    rd(8'h00);
    `CHK("unmapped", 32'h0000_0000, rdata_u)
    // Exceptions enter with mode 0, so the read shows the pc as is
    exc(1'b0, 1'b0, 32'h8000_1000, 32'h8000_0FF8, 32'hBFC0_0400);
    rd(ADDR_ERR_RET);
    `CHK("err_pc", 32'h8000_1000, rdata_u)
    exc(1'b1, 1'b0, 32'h8000_2004, 32'h8000_2000, 32'hBFC0_0400);
    rd(ADDR_ERR_RET);
    `CHK("err_slot", 32'h8000_2000, rdata_u)
    exc(1'b0, 1'b1, 32'h8000_3000, 32'h8000_2FF8, 32'hBFC0_0400);
    rd(ADDR_ERR_RET);
    `CHK("err_reset", 32'hBFC0_0400, rdata_u)
    vals = '{32'hFFFF_FFFF, 32'h8765_4322, 32'h0000_0001};
    for (int i = 0; i < 3; i++) begin
      v = vals[i];
      wr(ADDR_ERR_RET, v);
      rd(ADDR_ERR_RET);
      `CHK("err_wr", v, rdata_u)
      `CHK("err_wr_z", v, rdata_z)
      `CHK("mode_wr", {1'b0, v[0]}, mode_u)
      `CHK("mode_z", 2'h0, mode_z)
    end
    load_rd(ARR_DCACHE, 32'h1111_2222, 32'h3333_4444, ADDR_DCACHE_LOW);
    `CHK("dc_load", 32'h1111_2222, rdata_u)
    `CHK("dc_load_z", 32'h0000_0000, rdata_z)
    wr(ADDR_DCACHE_LOW, 32'h5555_6666);
    rd(ADDR_DCACHE_LOW);
    `CHK("dc_wr", 32'h5555_6666, rdata_u)
    `CHK("dc_wr_z", 32'h0000_0000, rdata_z)
    cop(1'b1, 1'b0, ARR_L2L3, 32'hAAAA_0001, 32'hBBBB_0002);
    rd(ADDR_L2L3_LOW);
    `CHK("l2_low", 32'hAAAA_0001, rdata_u)
    `CHK("l2_low_z", 32'h0000_0000, rdata_z)
    rd(ADDR_L2L3_HIGH);
    `CHK("l2_high", 32'hBBBB_0002, rdata_u)
    `CHK("l2_high_z", 32'h0000_0000, rdata_z)
    for (int be = 0; be < 2; be++) begin
      big_endian = be[0];
      cop(1'b1, 1'b0, ARR_ICACHE, 32'hC0DE_0000, 32'hC0DE_0004);
      rd(ADDR_ICACHE_HIGH);
      `CHK("ic_high", be ? 32'hC0DE_0000 : 32'hC0DE_0004, rdata_u)
      `CHK("ic_high_z", 32'h0000_0000, rdata_z)
      rd(ADDR_ICACHE_LOW);
      `CHK("ic_low", be ? 32'hC0DE_0004 : 32'hC0DE_0000, rdata_u)
    end
    exp_lo = '{32'hC0DE_0004, 32'h5555_6666, 32'hAAAA_0001};
    exp_hi = '{32'hC0DE_0000, 32'h0000_0000, 32'hBBBB_0002};
    for (int a = 0; a < 3; a++) begin
      for (int t = 0; t < 4; t++) begin
        way_select_test_enable = t[0];
        scratchpad_test_enable = t[1];
        exp_tgt = t[1] ? CDR_TGT_SPAD : (t[0] ? CDR_TGT_CACHE : CDR_TGT_NONE);
        cop(1'b0, 1'b1, a[1:0], 32'h0000_0000, 32'h0000_0000);
        `CHK("st_target", exp_tgt, tgt_u)
        `CHK("st_valid", exp_tgt != CDR_TGT_NONE, valid_u)
        if (t != 0) begin
          `CHK("st_lo", exp_lo[a], lo_u)
          // The dcache high word is not a defined part of its store
          if (a != 1) begin
            `CHK("st_hi", (a == 2 && t[1]) ? 32'h0 : exp_hi[a], hi_u)
          end
        end
      end
    end
    @(negedge ref_clk);
    `CHK("st_pulse", 1'b0, valid_u)
    rst = 1'b1;
    @(negedge ref_clk);
    rst = 1'b0;
    `CHK("mode_rerst", 2'h0, mode_u)
    `CHK("valid_rerst", 1'b0, valid_u)
    finish_test;
  end
endmodule
